// ### logic/scsm_pkg.sv
// Package with register map, field positions, reset values and timing for the smart-card UART.
// How it works
// (R1) Internal bit rate: prescaled clock over 16(n+1).
// (R2) External bit rate: clock pin over 16(n+1).
// (R3) Transmit starts when enabled and buffer full.
// (R4) Receive starts when enabled and start seen.
// (R5) Transmit irq at tick after stop bit.
// (R6) Receive irq when character reaches buffer.
// (R7) Overrun near stop bit; irq flag unchanged.
// (R8) Framing error when stop bit missing.
// (R9) Framing and parity flags update on transfer.
// (R10) Summary error flag on any error.
// (R11) Parity error drives output low when enabled.
// (R12) Buffer read clears parity error, releases line.
// (R13) Card pulls line low on parity error.
// (R14) Irq source plus error enable raises request.
// (R15) Handshake disabled, no flow control.
// (R16) Direct format: LSB first, even parity.
// (R17) Inverse format: inverted, MSB first, odd parity.
// (R18) Receive irq on rising buffer-full flag only.
// (R19) Mode code 101b selects smart-card mode.
// (R20) Frame: start, eight data, parity, stop.
package scsm_pkg;
    localparam logic [5:0] ADDR_TX_BUFFER = 6'h00;
    localparam logic [5:0] ADDR_RX_BUFFER = 6'h04;
    localparam logic [5:0] ADDR_BAUD_DIVIDER = 6'h08;
    localparam logic [5:0] ADDR_MODE_SETUP = 6'h0c;
    localparam logic [5:0] ADDR_CONTROL_ZERO = 6'h10;
    localparam logic [5:0] ADDR_CONTROL_ONE = 6'h14;
    localparam logic [5:0] ADDR_SPECIAL_ONE = 6'h18;
    localparam logic [5:0] ADDR_SPECIAL_TWO = 6'h1c;
    localparam logic [5:0] ADDR_SPECIAL_THREE = 6'h20;
    localparam logic [5:0] ADDR_SPECIAL_FOUR = 6'h24;
    localparam logic [5:0] ADDR_IRQ_STATUS = 6'h28;
    // Mode register fields.
    localparam int MR_MODE_LSB = 0;
    localparam int MR_CLKSRC = 3;
    localparam int MR_STOPS = 4;
    localparam int MR_PARSENSE = 5;
    localparam int MR_PARENA = 6;
    localparam logic [2:0] MODE_SIM = 3'h5;
    // Control zero fields.
    localparam int C0_PRESCALE_LSB = 0;
    localparam int C0_TXEMPTY = 3;
    localparam int C0_HSDIS = 4;
    localparam int C0_ORDER = 7;
    // Control one fields.
    localparam int C1_TXEN = 0;
    localparam int C1_TXBE = 1;
    localparam int C1_RXEN = 2;
    localparam int C1_RXBF = 3;
    localparam int C1_IRQSRC = 4;
    localparam int C1_INVERT = 6;
    localparam int C1_ERREN = 7;
    // Receive buffer upper-byte flags.
    localparam int RB_OVERRUN = 12;
    localparam int RB_FRAMING = 13;
    localparam int RB_PARITY = 14;
    localparam int RB_SUM = 15;
    // Interrupt status fields, write one to clear.
    localparam int IS_TX = 0;
    localparam int IS_RX = 1;
    localparam logic [7:0] RESET_MODE = 8'h00;
    localparam logic [7:0] RESET_CONTROL_ZERO = 8'h18;
    localparam logic [7:0] RESET_CONTROL_ONE = 8'h02;
    localparam logic [7:0] RESET_DIVIDER = 8'h00;
    localparam int OVERSAMPLE = 16;
    localparam int PRESCALE_F8 = 8;
    localparam int PRESCALE_F32 = 32;
    localparam int FRAME_BITS = 11;
endpackage

// ### logic/scsm_baud_gen.sv
// Bit-rate generator giving a sixteen-times oversample enable pulse.
`timescale 1ns/100ps
module scsm_baud_gen (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Configuration.
    input wire logic [1:0] prescaleSel,
    input wire logic extSelect,
    input wire logic [7:0] baudDivider,
    // External clock sampled level.
    input wire logic extClock,
    // Oversample enable.
    output logic tick16
);
    import scsm_pkg::*;
    logic [4:0] preCount_r;
    logic [7:0] divCount_r;
    logic extPrev_r;
    logic preTick;
    logic srcTick;
    logic [4:0] preLimit;

    assign preLimit = (prescaleSel == 2'h0) ? 5'h00 :
                      (prescaleSel == 2'h1) ? 5'h01 :
                      (prescaleSel == 2'h2) ? 5'(PRESCALE_F8 - 1) : 5'(PRESCALE_F32 - 1);
    assign preTick = (preCount_r >= preLimit);
    assign srcTick = extSelect ? (extClock & ~extPrev_r) : preTick; // (R2)
    assign tick16 = srcTick && (divCount_r == 8'h00); // (R1)

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            preCount_r <= 5'h00;
            divCount_r <= 8'h00;
            extPrev_r <= 1'b0;
        end else begin
            extPrev_r <= extClock;
            preCount_r <= preTick ? 5'h00 : preCount_r + 5'h01;
            if (srcTick) begin
                divCount_r <= (divCount_r == 8'h00) ? baudDivider : divCount_r - 8'h01; // (R1)
            end
        end
    end
endmodule

// ### logic/scsm_sim_uart.sv
// Smart-card serial channel with Wishbone register access.
`timescale 1ns/100ps
module scsm_sim_uart (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial pins.
    input wire logic serialInPin,
    input wire logic extClockPin,
    output logic serialOutPin,
    output logic serialOutOe,
    // Interrupt request flags.
    output logic txIrqFlag,
    output logic rxIrqFlag
);
    import scsm_pkg::*;

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_DONE} scsm_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} scsm_rx_e;

    logic [7:0] modeSetup_r;
    logic [7:0] control0_r;
    logic [7:0] control1_r;
    logic [7:0] baudDivider_r;
    logic [7:0] special1_r;
    logic [7:0] special2_r;
    logic [7:0] special3_r;
    logic [7:0] special4_r;
    logic [7:0] txBuffer_r;
    logic [7:0] rxData_r;
    logic overrun_r;
    logic framing_r;
    logic parityErr_r;
    logic txIrq_r;
    logic rxIrq_r;
    logic ack_r;
    logic [31:0] rdData_r;
    logic txOut_r;
    logic errDrive_r;
    logic pinOut_r;
    logic pinOe_r;
    scsm_tx_e txState_r;
    scsm_rx_e rxState_r;
    logic [9:0] txShift_r;
    logic [3:0] txBits_r;
    logic [3:0] txPhase_r;
    logic [3:0] rxPhase_r;
    logic [3:0] rxBits_r;
    logic [8:0] rxShift_r;
    logic rxPrev_r;
    logic ovPending_r;
    logic txBusy;

    // Bus decode.
    logic wbReq;
    logic wbWrite;
    logic wbRead;
    logic tick16;
    logic simMode;
    logic invert;
    logic msbFirst;
    logic paritySense;
    logic [7:0] txCoded;
    logic txParity;
    logic rxBit;
    logic [7:0] rxOrdered;
    logic [7:0] rxCoded;
    logic rxParityBad;
    logic rxSample;
    logic txBitEnd;
    logic rxDone;
    logic rxStopOk;
    logic readRxBuffer;
    logic [31:0] rdMux;
    logic rxBufferFull;
    logic txBufferEmpty;

    assign wbReq = wb_cyc_i && wb_stb_i && !ack_r;
    assign wbWrite = wbReq && wb_we_i && wb_sel_i[0];
    assign wbRead = wbReq && !wb_we_i;
    assign readRxBuffer = wbRead && (wb_adr_i == ADDR_RX_BUFFER);
    assign simMode = (modeSetup_r[MR_MODE_LSB +: 3] == MODE_SIM); // (R19)
    assign invert = control1_r[C1_INVERT];
    assign msbFirst = control0_r[C0_ORDER];
    assign paritySense = modeSetup_r[MR_PARSENSE];
    assign rxBufferFull = control1_r[C1_RXBF];
    assign txBufferEmpty = control1_r[C1_TXBE];
    assign txBusy = (txState_r != TX_IDLE);

    // Format: inversion and bit order for both directions.
    assign txCoded = invert ? ~txBuffer_r : txBuffer_r; // (R17)
    // Parity sense 1 is even, 0 is odd.
    assign txParity = (^txCoded) ^ ~paritySense; // (R16) (R17)
    assign rxOrdered = msbFirst ? rxShift_r[8:1] : {rxShift_r[1], rxShift_r[2], rxShift_r[3],
                       rxShift_r[4], rxShift_r[5], rxShift_r[6], rxShift_r[7], rxShift_r[8]};
    assign rxCoded = invert ? ~rxOrdered : rxOrdered; // (R17)
    assign rxParityBad = modeSetup_r[MR_PARENA] &&
                         (((^rxShift_r[8:1]) ^ rxShift_r[0] ^ ~paritySense) != 1'b0); // (R16)
    assign rxBit = serialInPin;
    assign rxSample = tick16 && (rxPhase_r == 4'h7);
    assign txBitEnd = tick16 && (txPhase_r == 4'hf);
    assign rxStopOk = rxBit;
    assign rxDone = rxSample && (rxState_r == RX_SHIFT) && (rxBits_r == 4'ha);

    scsm_baud_gen u_baud (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .prescaleSel(control0_r[C0_PRESCALE_LSB +: 2]),
        .extSelect(modeSetup_r[MR_CLKSRC]),
        .baudDivider(baudDivider_r),
        .extClock(extClockPin),
        .tick16(tick16)
    );

    always_comb begin
        unique case (wb_adr_i)
            ADDR_TX_BUFFER: rdMux = 32'h0;
            ADDR_RX_BUFFER: rdMux = {16'h0, overrun_r | framing_r | parityErr_r, parityErr_r,
                                      framing_r, overrun_r, 4'h0, rxData_r}; // (R10)
            ADDR_BAUD_DIVIDER: rdMux = {24'h0, baudDivider_r};
            ADDR_MODE_SETUP: rdMux = {24'h0, modeSetup_r};
            ADDR_CONTROL_ZERO: rdMux = {24'h0, control0_r[7:5], 1'b1, ~txBusy, control0_r[2:0]};
            ADDR_CONTROL_ONE: rdMux = {24'h0, control1_r};
            ADDR_SPECIAL_ONE: rdMux = {24'h0, special1_r};
            ADDR_SPECIAL_TWO: rdMux = {24'h0, special2_r};
            ADDR_SPECIAL_THREE: rdMux = {24'h0, special3_r};
            ADDR_SPECIAL_FOUR: rdMux = {24'h0, special4_r};
            ADDR_IRQ_STATUS: rdMux = {30'h0, rxIrq_r, txIrq_r};
            default: rdMux = 32'h0;
        endcase
    end

    // Bus slave: one wait state, ack for one cycle.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ack_r <= 1'b0;
            rdData_r <= 32'h0;
        end else begin
            ack_r <= wbReq;
            rdData_r <= wbRead ? rdMux : 32'h0;
        end
    end

    // Configuration registers.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            modeSetup_r <= RESET_MODE;
            baudDivider_r <= RESET_DIVIDER;
            special1_r <= 8'h00;
            special2_r <= 8'h00;
            special3_r <= 8'h00;
            special4_r <= 8'h00;
        end else if (wbWrite) begin
            if (wb_adr_i == ADDR_MODE_SETUP) modeSetup_r <= wb_dat_i[7:0];
            if (wb_adr_i == ADDR_BAUD_DIVIDER) baudDivider_r <= wb_dat_i[7:0];
            if (wb_adr_i == ADDR_SPECIAL_ONE) special1_r <= wb_dat_i[7:0];
            if (wb_adr_i == ADDR_SPECIAL_TWO) special2_r <= wb_dat_i[7:0];
            if (wb_adr_i == ADDR_SPECIAL_THREE) special3_r <= wb_dat_i[7:0];
            if (wb_adr_i == ADDR_SPECIAL_FOUR) special4_r <= wb_dat_i[7:0];
        end
    end

    // Control zero: handshake disable forced, transmit-empty is status.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            control0_r <= RESET_CONTROL_ZERO;
        end else if (wbWrite && wb_adr_i == ADDR_CONTROL_ZERO) begin
            control0_r <= {wb_dat_i[7:5], 1'b1, 1'b1, wb_dat_i[2:0]}; // (R15)
        end
    end

    // Control one with hardware-owned buffer flags; hardware set wins.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            control1_r <= RESET_CONTROL_ONE;
            txBuffer_r <= 8'h00;
        end else begin
            if (wbWrite && wb_adr_i == ADDR_CONTROL_ONE) begin
                control1_r[C1_TXEN] <= wb_dat_i[C1_TXEN];
                control1_r[C1_RXEN] <= wb_dat_i[C1_RXEN];
                control1_r[7:4] <= wb_dat_i[7:4];
            end
            if (wbWrite && wb_adr_i == ADDR_TX_BUFFER) begin
                txBuffer_r <= wb_dat_i[7:0];
                control1_r[C1_TXBE] <= 1'b0;
            end
            if (txState_r == TX_IDLE && control1_r[C1_TXEN] && !txBufferEmpty && simMode) begin
                control1_r[C1_TXBE] <= 1'b1; // (R3)
            end
            if (readRxBuffer) control1_r[C1_RXBF] <= 1'b0;
            if (rxDone) control1_r[C1_RXBF] <= 1'b1; // (R6)
        end
    end

    // Transmitter.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            txState_r <= TX_IDLE;
            txShift_r <= 10'h3ff;
            txBits_r <= 4'h0;
            txPhase_r <= 4'h0;
            txOut_r <= 1'b1;
        end else begin
            unique case (txState_r)
                TX_IDLE: begin
                    txOut_r <= 1'b1;
                    if (control1_r[C1_TXEN] && !txBufferEmpty && simMode) begin // (R3)
                        txState_r <= TX_SHIFT;
                        txOut_r <= 1'b0; // (R20)
                        txPhase_r <= 4'h0;
                        txBits_r <= 4'h0;
                        txShift_r <= {msbFirst ? txCoded : {txCoded[0], txCoded[1],
                            txCoded[2], txCoded[3], txCoded[4], txCoded[5], txCoded[6],
                            txCoded[7]}, txParity, 1'b1}; // (R16) (R17)
                    end
                end
                TX_SHIFT: begin
                    if (tick16) txPhase_r <= txPhase_r + 4'h1;
                    if (txBitEnd) begin
                        txBits_r <= txBits_r + 4'h1;
                        txOut_r <= txShift_r[9];
                        txShift_r <= {txShift_r[8:0], 1'b1};
                        if (txBits_r == 4'(FRAME_BITS - 1)) txState_r <= TX_DONE;
                    end
                end
                TX_DONE: begin
                    txOut_r <= 1'b1;
                    if (tick16) txState_r <= TX_IDLE; // (R5)
                end
                default: txState_r <= TX_IDLE;
            endcase
        end
    end

    // Receiver.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rxState_r <= RX_IDLE;
            rxPhase_r <= 4'h0;
            rxBits_r <= 4'h0;
            rxShift_r <= 9'h000;
            rxPrev_r <= 1'b1;
            rxData_r <= 8'h00;
            overrun_r <= 1'b0;
            framing_r <= 1'b0;
            parityErr_r <= 1'b0;
            ovPending_r <= 1'b0;
        end else begin
            rxPrev_r <= rxBit;
            if (readRxBuffer) begin
                overrun_r <= 1'b0;
                parityErr_r <= 1'b0; // (R12)
            end
            unique case (rxState_r)
                RX_IDLE: begin
                    if (control1_r[C1_RXEN] && simMode && rxPrev_r && !rxBit &&
                        !errDrive_r) begin // (R4)
                        rxState_r <= RX_SHIFT;
                        rxPhase_r <= 4'h0;
                        rxBits_r <= 4'h0;
                    end
                end
                RX_SHIFT: begin
                    if (tick16) rxPhase_r <= rxPhase_r + 4'h1;
                    if (rxSample) begin
                        rxBits_r <= rxBits_r + 4'h1;
                        if (rxBits_r == 4'h0 && rxBit) rxState_r <= RX_IDLE;
                        if (rxBits_r != 4'h0 && rxBits_r != 4'ha) rxShift_r <= {rxShift_r[7:0], rxBit};
                        if (rxBits_r == 4'h9 && rxBufferFull && !readRxBuffer) begin
                            overrun_r <= 1'b1; // (R7)
                        end
                        if (rxDone) begin
                            rxState_r <= RX_IDLE;
                            rxData_r <= rxCoded; // (R9)
                            framing_r <= !rxStopOk; // (R8) (R9)
                            parityErr_r <= rxParityBad; // (R9)
                        end
                    end
                end
                default: rxState_r <= RX_IDLE;
            endcase
        end
    end

    // Error signal holds the line low until the buffer is read.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            errDrive_r <= 1'b0;
        end else if (rxDone && rxParityBad && control1_r[C1_ERREN]) begin
            errDrive_r <= 1'b1; // (R11)
        end else if (readRxBuffer) begin
            errDrive_r <= 1'b0; // (R12)
        end
    end

    // Interrupt flags: write one to clear at the status register; set wins.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            txIrq_r <= 1'b0;
            rxIrq_r <= 1'b0;
        end else begin
            if (wbWrite && wb_adr_i == ADDR_IRQ_STATUS && wb_dat_i[IS_TX]) txIrq_r <= 1'b0;
            if (wbWrite && wb_adr_i == ADDR_IRQ_STATUS && wb_dat_i[IS_RX]) rxIrq_r <= 1'b0;
            if (txState_r == TX_DONE && tick16 && control1_r[C1_IRQSRC]) txIrq_r <= 1'b1; // (R5)
            if (wbWrite && wb_adr_i == ADDR_CONTROL_ONE && wb_dat_i[C1_IRQSRC] &&
                wb_dat_i[C1_ERREN] && !(control1_r[C1_IRQSRC] && control1_r[C1_ERREN])) begin
                txIrq_r <= 1'b1; // (R14)
            end
            if (rxDone && !rxBufferFull) rxIrq_r <= 1'b1; // (R18) (R6)
        end
    end

    // Open-drain output: drive only when low; card error visible on serialInPin (R13).
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pinOut_r <= 1'b1;
            pinOe_r <= 1'b0;
        end else begin
            pinOut_r <= txOut_r & ~errDrive_r; // (R11)
            pinOe_r <= ~(txOut_r & ~errDrive_r);
        end
    end

    assign serialOutPin = pinOut_r;
    assign serialOutOe = pinOe_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdData_r;
    assign txIrqFlag = txIrq_r;
    assign rxIrqFlag = rxIrq_r;
endmodule

// ### tb/scsm_sim_uart_checker.sv
// Port-level assertions for the smart-card serial channel.
`timescale 1ns/100ps
module scsm_sim_uart_checker (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Line drive and interrupt flags.
    input wire logic serialOutPin,
    input wire logic serialOutOe,
    input wire logic txIrqFlag,
    input wire logic rxIrqFlag
);
    import scsm_pkg::*;
    logic bothSet_r;
    wire logic busWr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    wire logic wrCtl1 = busWr && wb_adr_i == ADDR_CONTROL_ONE;
    wire logic wrIrq = busWr && wb_adr_i == ADDR_IRQ_STATUS;
    wire logic rdRxBuf = wb_ack_o && !wb_we_i && wb_adr_i == ADDR_RX_BUFFER;
    wire logic unmapped = wb_adr_i > ADDR_IRQ_STATUS || wb_adr_i[1:0] != 2'h0;
    wire logic bothNew = wb_dat_i[C1_IRQSRC] && wb_dat_i[C1_ERREN];

    // Tracks whether the source and error-signal bits were both already set.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            bothSet_r <= 1'b0;
        end else if (wrCtl1) begin
            bothSet_r <= bothNew;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_ack_one;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack missing");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
    property p_unmapped;
        wb_ack_o && !wb_we_i && unmapped |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_od_low;
        serialOutOe |-> !serialOutPin;
    endproperty
    a_od_low: assert property (p_od_low) else $error("drive not low");
    property p_pe_release;
        rdRxBuf |=> !serialOutOe;
    endproperty
    a_pe_release: assert property (p_pe_release) else $error("line held");
    property p_irq_setup;
        wrCtl1 && bothNew && !bothSet_r |-> ##[1:2] txIrqFlag;
    endproperty
    a_irq_setup: assert property (p_irq_setup) else $error("no setup irq");
    property p_rx_hold;
        rxIrqFlag && !(wrIrq && wb_dat_i[IS_RX]) |=> rxIrqFlag;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx flag lost");
    property p_tx_hold;
        txIrqFlag && !(wrIrq && wb_dat_i[IS_TX]) |=> txIrqFlag;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx flag lost");
endmodule

bind scsm_sim_uart scsm_sim_uart_checker i_chk (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .serialOutPin,
    .serialOutOe, .txIrqFlag, .rxIrqFlag);

// ### tb/scsm_card_model.sv
// Behavioural smart card on the shared pulled-up data line.
`timescale 1ns/100ps
module scsm_card_model (
    // Clock.
    input wire logic clk_sys,
    // Shared line.
    input wire logic lineLevel,
    output logic pullLow
);
    int etu = 96;
    logic inv = 1'b0;
    logic listen = 1'b0;
    logic nackNext = 1'b0;
    logic sendLow = 1'b0;
    logic nackLow = 1'b0;
    logic [9:0] rxRaw = 10'h0;
    assign pullLow = sendLow | nackLow;

    // Sends raw line levels; a low stop level makes a framing fault on purpose.
    task automatic send(input logic [7:0] bits, input logic par, input logic stopHi);
        sendLow <= 1'b1;
        repeat (etu) @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            sendLow <= i < 8 ? !bits[i] : i == 8 ? !par : !stopHi;
            repeat (etu) @(posedge clk_sys);
        end
        sendLow <= 1'b0;
        repeat (2 * etu) @(posedge clk_sys);
    endtask

    // Samples mid-bit and answers a bad parity with a low pulse over the stop end.
    initial begin
        forever begin
            @(negedge lineLevel);
            if (listen) begin
                repeat (etu / 2) @(posedge clk_sys);
                for (int i = 0; i < 10; i++) begin
                    repeat (etu) @(posedge clk_sys);
                    rxRaw[i] = lineLevel;
                end
                if (nackNext || (^rxRaw[8:0]) != inv) begin
                    nackLow <= 1'b1;
                    repeat (etu * 3 / 2) @(posedge clk_sys);
                    nackLow <= 1'b0;
                    nackNext = 1'b0;
                end
            end
        end
    end
endmodule

// ### tb/scsm_sim_uart_tb.sv
// Self-checking bench for the smart-card serial channel.
`timescale 1ns/100ps
module scsm_sim_uart_tb;
    import scsm_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, serialOutPin, serialOutOe, txIrqFlag, rxIrqFlag, cardLow;
    logic serialInPin = 1'b1;
    logic extClockPin = 1'b0;
    logic extPhase = 1'b0;
    logic [7:0] txSet [3] = '{8'ha5, 8'h00, 8'hff};
    int err_count = 0;
    int n_checks = 0;
    wire logic lineLevel = !((serialOutOe && !serialOutPin) | cardLow);

    scsm_sim_uart i_dut (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .serialInPin, .extClockPin,
        .serialOutPin, .serialOutOe, .txIrqFlag, .rxIrqFlag);
    scsm_card_model i_card (.clk_sys(clk_sys), .lineLevel(lineLevel), .pullLow(cardLow));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // The outside bit clock runs at a quarter of the system rate.
    always @(posedge clk_sys) begin
        serialInPin <= lineLevel;
        extPhase <= !extPhase;
        if (extPhase) extClockPin <= !extClockPin;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fail(input string what);
        err_count++;
        $display("[ERR] %0t %s timed out", $time, what);
        close_out();
    endtask
    task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1) begin
            n++;
            if (n > 40) fail("bus");
            @(posedge clk_sys);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask
    task automatic waitSig(input int which);
        int n;
        n = 0;
        n_checks++;
        while ((which == 0 ? txIrqFlag : which == 1 ? rxIrqFlag : serialOutOe) !== 1'b1) begin
            n++;
            if (n > 4000) fail("wait");
            @(posedge clk_sys);
        end
    endtask
    // Line levels of data then parity, first bit in bit 0.
    function automatic logic [8:0] lineBits(input logic [7:0] d, input logic inv);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = inv ? !d[7 - i] : d[i];
        return {^r ^ inv, r};
    endfunction
    task automatic txOne(input logic [7:0] d, input logic inv);
        wr(ADDR_TX_BUFFER, d);
        waitSig(0);
        check(32'(serialInPin), 32'h1);
        check(32'(i_card.rxRaw), {22'h0, 1'b1, lineBits(d, inv)});
        wr(ADDR_IRQ_STATUS, 8'h01);
    endtask
    task automatic rxOne(input logic [7:0] d, input logic inv, input logic parOk,
                         input logic stopOk, input logic [3:0] flags);
        logic [8:0] b;
        logic [31:0] q;
        b = lineBits(d, inv);
        i_card.send(b[7:0], b[8] ^ !parOk, stopOk);
        waitSig(1);
        if (!parOk) waitSig(2);
        wr(ADDR_IRQ_STATUS, 8'h02);
        bus(1'b0, ADDR_RX_BUFFER, 8'h00, q);
        check(q, {16'h0, flags, 4'h0, d});
        check(32'(serialOutOe), 32'h0);
    endtask

    initial begin
        logic [8:0] b;
        logic [31:0] q;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        rdchk(ADDR_MODE_SETUP, {24'h0, RESET_MODE});
        rdchk(ADDR_CONTROL_ZERO, {24'h0, RESET_CONTROL_ZERO});
        rdchk(ADDR_CONTROL_ONE, {24'h0, RESET_CONTROL_ONE});
        rdchk(ADDR_BAUD_DIVIDER, {24'h0, RESET_DIVIDER});
        wr(ADDR_SPECIAL_ONE, 8'h5a);
        rdchk(ADDR_SPECIAL_ONE, 32'h5a);
        wr(6'h3c, 8'h77);
        rdchk(6'h3c, 32'h0);
        $display("test registers done");
        wr(ADDR_BAUD_DIVIDER, 8'h02);
        wr(ADDR_CONTROL_ZERO, 8'h01);
        wr(ADDR_MODE_SETUP, 8'h65);
        wr(ADDR_CONTROL_ONE, 8'h91);
        waitSig(0);
        wr(ADDR_IRQ_STATUS, 8'h03);
        check(32'(txIrqFlag), 32'h0);
        i_card.listen = 1'b1;
        foreach (txSet[i]) txOne(txSet[i], 1'b0);
        i_card.nackNext = 1'b1;
        wr(ADDR_TX_BUFFER, 8'h5a);
        waitSig(0);
        check(32'(serialInPin), 32'h0);
        wr(ADDR_IRQ_STATUS, 8'h01);
        repeat (192) @(posedge clk_sys);
        i_card.listen = 1'b0;
        $display("test direct send done");
        wr(ADDR_CONTROL_ONE, 8'h94);
        wr(ADDR_IRQ_STATUS, 8'h03);
        rxOne(8'hc3, 1'b0, 1'b1, 1'b1, 4'h0);
        rxOne(8'h3a, 1'b0, 1'b0, 1'b1, 4'hc);
        rxOne(8'h81, 1'b0, 1'b1, 1'b0, 4'ha);
        $display("test direct receive done");
        b = lineBits(8'h11, 1'b0);
        i_card.send(b[7:0], b[8], 1'b1);
        waitSig(1);
        wr(ADDR_IRQ_STATUS, 8'h02);
        b = lineBits(8'h22, 1'b0);
        i_card.send(b[7:0], b[8], 1'b1);
        check(32'(rxIrqFlag), 32'h0);
        bus(1'b0, ADDR_RX_BUFFER, 8'h00, q);
        check(q & 32'h0000f000, 32'h00009000);
        $display("test overrun done");
        i_card.etu = 128;
        i_card.inv = 1'b1;
        wr(ADDR_BAUD_DIVIDER, 8'h01);
        wr(ADDR_CONTROL_ZERO, 8'h80);
        wr(ADDR_MODE_SETUP, 8'h4d);
        wr(ADDR_CONTROL_ONE, 8'hd1);
        wr(ADDR_IRQ_STATUS, 8'h03);
        i_card.listen = 1'b1;
        txOne(8'h96, 1'b1);
        i_card.listen = 1'b0;
        wr(ADDR_CONTROL_ONE, 8'hd4);
        wr(ADDR_IRQ_STATUS, 8'h03);
        rxOne(8'h1e, 1'b1, 1'b1, 1'b1, 4'h0);
        $display("test inverse done");
        close_out();
    end
endmodule
